// ---- src/serial_port_defines.svh ----
// Purpose: constants of the clocked serial port: offsets, bit positions, reset values
// Assumes: included by bare name from the design files
// Notes: register offsets are word indices on a 3-bit register address
`ifndef SERIAL_PORT_DEFINES_SVH
`define SERIAL_PORT_DEFINES_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define BAUD_CONTROL_OFF 3'h0
`define RECEIVE_STATUS_CONTROL_OFF 3'h1
`define RATE_DIVISOR_LOW_OFF 3'h2
`define RATE_DIVISOR_HIGH_OFF 3'h3
`define TRANSMIT_DATA_OFF 3'h4
`define TRANSMIT_STATUS_CONTROL_OFF 3'h5
`define RECEIVE_DATA_OFF 3'h6
`define FLAG_STATUS_OFF 3'h7

// ----------------------------------------------------------------------------
// baud_control bits
// ----------------------------------------------------------------------------
`define BAUD_IDLE_BIT 6
`define BAUD_CLOCK_POLARITY_SELECT_BIT 4
`define BAUD_WIDE_BIT 3
`define BAUD_WAKE_BIT 1
`define BAUD_AUTO_BIT 0

// ----------------------------------------------------------------------------
// receive_status_control bits
// ----------------------------------------------------------------------------
`define RX_PORT_EN_BIT 7
`define RX_NINE_EN_BIT 6
`define RX_SINGLE_BIT 5
`define RX_CONT_BIT 4
`define RX_ADDR_EN_BIT 3
`define RX_FRAME_ERR_BIT 2
`define RX_OVERRUN_BIT 1
`define RX_NINTH_DATA_BIT 0

// ----------------------------------------------------------------------------
// transmit_status_control bits
// ----------------------------------------------------------------------------
`define TX_MASTER_BIT 7
`define TX_NINE_EN_BIT 6
`define TX_EN_BIT 5
`define TX_SYNC_BIT 4
`define TX_BREAK_BIT 3
`define TX_HIGH_RATE_BIT 2
`define TX_EMPTY_BIT 1
`define TX_NINTH_DATA_BIT 0

// ----------------------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------------------
`define BAUD_CONTROL_RESET 8'h00
`define RECEIVE_STATUS_RESET 8'h00
`define TRANSMIT_STATUS_RESET 8'h00
`define RATE_DIVISOR_RESET 16'h0000
`define FIFO_ENTRIES 2

`endif

// ---- src/serial_port_pkg.sv ----
// Purpose: types shared by the clocked serial port
// Assumes: nothing
// Notes: one-hot engine states
package serial_port_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_TX = 4'b0010,
    ST_RX = 4'b0100,
    ST_ARX = 4'b1000
  } engine_state_e;
endpackage

// ---- src/serial_port_unit.sv ----
// Purpose: clocked master/slave serial port with two-entry receive queue and break receive
// Assumes: core_clk 40 MHz; clock and data pins arrive unsynchronised
// Notes: one rate tick is one half period of the master clock, or one bit time when unclocked
`include "serial_port_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module serial_port_unit #(
  parameter int ADDR_W = 3
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic clock_pin_in,
  output logic clock_pin_out,
  output logic clock_pin_oe,
  input wire logic data_line_pin_in,
  output logic data_line_pin_out,
  output logic data_line_pin_oe,
  output logic receive_flag,
  output logic transmit_flag
);
  import serial_port_pkg::*;

  if (ADDR_W != 3) begin : g_check
    $error("serial_port_unit: ADDR_W must be 3");
  end

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  logic clock_polarity_select, wide_divider_select, wake_on_activity_enable;
  logic auto_rate_detect_enable, port_enable, rx_ninth_bit_enable;
  logic single_receive_enable, continuous_receive_enable, address_detect_enable;
  logic clock_source_master, tx_ninth_bit_enable, transmit_enable, sync_mode;
  logic send_break_request, high_rate_select, transmit_ninth_data_bit;
  logic [15:0] rate_divisor, rate_cnt;
  logic clk_s1, clk_s2, clk_s3, din_s1, din_s2, din_s3;
  engine_state_e state;
  logic [3:0] bit_cnt;
  logic [8:0] transmit_shifter, receive_shifter, tx_hold;
  logic hold_valid, clk_active, data_out, overrun_flag, overrun_cont, wake_flag;
  logic [9:0] fifo_mem [0:`FIFO_ENTRIES-1];
  logic wr_ptr, rd_ptr;
  logic [1:0] fifo_count;

  // first bit in is the lowest one; shift the eight-bit case down
  function automatic logic [8:0] align_char(input logic [8:0] sh, input logic nine);
    align_char = nine ? sh : {1'b0, sh[8:1]};
  endfunction

  // --------------------------------------------------------------------------
  // decode
  // --------------------------------------------------------------------------
  wire wr_baud = reg_write & (reg_addr == `BAUD_CONTROL_OFF);
  wire wr_receive_status_control = reg_write & (reg_addr == `RECEIVE_STATUS_CONTROL_OFF);
  wire wr_divl = reg_write & (reg_addr == `RATE_DIVISOR_LOW_OFF);
  wire wr_divh = reg_write & (reg_addr == `RATE_DIVISOR_HIGH_OFF);
  wire wr_txdata = reg_write & (reg_addr == `TRANSMIT_DATA_OFF);
  wire wr_transmit_status_control = reg_write & (reg_addr == `TRANSMIT_STATUS_CONTROL_OFF);
  wire rd_rxdata = reg_read & (reg_addr == `RECEIVE_DATA_OFF);
  wire st_idle = (state == ST_IDLE);
  wire st_tx = (state == ST_TX);
  wire st_rx = (state == ST_RX);
  wire st_arx = (state == ST_ARX);
  wire port_reset = ~port_enable; // clearing the port enable resets the port
  wire tick = (rate_cnt == 16'h0000);
  wire din_fall = din_s3 & ~din_s2;
  wire din_rise = ~din_s3 & din_s2;
  wire [3:0] nbits_tx = tx_ninth_bit_enable ? 4'h9 : 4'h8;
  wire [3:0] nbits_rx = rx_ninth_bit_enable ? 4'h9 : 4'h8;
  wire fifo_empty = (fifo_count == 2'h0);
  wire [9:0] fifo_top = fifo_mem[rd_ptr];

  // mode selection: in clocked mode, transmit enable with both receive enables clear means transmit
  wire clocked_on = sync_mode & port_enable;
  wire master = clocked_on & clock_source_master;
  wire tx_mode = clocked_on & transmit_enable & ~single_receive_enable
    & ~continuous_receive_enable;
  // slave ignores the single receive bit; overrun stops new characters
  wire rx_mode = clocked_on & ~overrun_flag & (continuous_receive_enable
    | (clock_source_master & single_receive_enable));
  wire busy = st_tx | st_rx;

  // edges of the link clock: generated as master, found on the pin as slave
  wire slave_lead = (clk_s3 == clock_polarity_select) & (clk_s2 != clock_polarity_select);
  wire slave_trail = (clk_s3 != clock_polarity_select) & (clk_s2 == clock_polarity_select);
  wire lead_ev = master ? (tick & busy & ~clk_active) : (clocked_on & busy & slave_lead);
  wire trail_ev = master ? (tick & busy & clk_active) : (clocked_on & busy & slave_trail);

  // engine events
  wire start_tx = st_idle & tx_mode & hold_valid;
  wire start_rx = st_idle & rx_mode;
  wire abort_rx = st_rx & ~rx_mode;
  wire wake_watch = wake_on_activity_enable & ~sync_mode & port_enable;
  wire arx_start = st_idle & ~sync_mode & port_enable & continuous_receive_enable
    & ~wake_on_activity_enable & din_fall;
  wire arx_sample = st_arx & tick;
  wire [8:0] rx_next = {din_s2, receive_shifter[8:1]};
  wire tx_last = st_tx & trail_ev & (bit_cnt == nbits_tx - 4'h1);
  wire rx_done = st_rx & trail_ev & (bit_cnt == nbits_rx - 4'h1);
  wire arx_done = arx_sample & (bit_cnt == nbits_rx + 4'h1);
  wire push_req = rx_done | arx_done;
  // stop bit sampled low marks a framing error; all-zero data with it is a break
  wire [9:0] push_word = arx_done ? {~din_s2, align_char(receive_shifter, rx_ninth_bit_enable)}
    : {1'b0, align_char(rx_next, rx_ninth_bit_enable)};
  wire single_receive_enable_clear = rx_done & clock_source_master & single_receive_enable;
  wire overrun_clear = overrun_cont ? ~continuous_receive_enable : rd_rxdata;

  // --------------------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------------------
  // two flops per pin; the third flop is the edge-detect history
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      {clk_s1, clk_s2, clk_s3} <= 3'h0;
      {din_s1, din_s2, din_s3} <= 3'h7;
    end else begin
      {clk_s1, clk_s2, clk_s3} <= {clock_pin_in, clk_s1, clk_s2};
      {din_s1, din_s2, din_s3} <= {data_line_pin_in, din_s1, din_s2};
    end
  end

  // --------------------------------------------------------------------------
  // control registers
  // --------------------------------------------------------------------------
  // software writes win over hardware clears of the same bit
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      {clock_polarity_select, wide_divider_select} <= 2'h0;
      {wake_on_activity_enable, auto_rate_detect_enable} <= 2'h0;
      {port_enable, rx_ninth_bit_enable, single_receive_enable} <= 3'h0;
      {continuous_receive_enable, address_detect_enable} <= 2'h0;
      {clock_source_master, tx_ninth_bit_enable, transmit_enable, sync_mode} <= 4'h0;
      {send_break_request, high_rate_select, transmit_ninth_data_bit} <= 3'h0;
      rate_divisor <= `RATE_DIVISOR_RESET;
    end else begin
      if (wr_baud) begin
        clock_polarity_select <= reg_wdata[`BAUD_CLOCK_POLARITY_SELECT_BIT];
        wide_divider_select <= reg_wdata[`BAUD_WIDE_BIT];
        wake_on_activity_enable <= reg_wdata[`BAUD_WAKE_BIT];
        auto_rate_detect_enable <= reg_wdata[`BAUD_AUTO_BIT];
      end else if (wake_watch & din_rise) begin
        wake_on_activity_enable <= 1'b0;
      end
      if (wr_receive_status_control) begin
        port_enable <= reg_wdata[`RX_PORT_EN_BIT];
        rx_ninth_bit_enable <= reg_wdata[`RX_NINE_EN_BIT];
        single_receive_enable <= reg_wdata[`RX_SINGLE_BIT];
        continuous_receive_enable <= reg_wdata[`RX_CONT_BIT];
        address_detect_enable <= reg_wdata[`RX_ADDR_EN_BIT];
      end else if (single_receive_enable_clear) begin
        single_receive_enable <= 1'b0;
      end
      if (wr_transmit_status_control) begin
        clock_source_master <= reg_wdata[`TX_MASTER_BIT];
        tx_ninth_bit_enable <= reg_wdata[`TX_NINE_EN_BIT];
        transmit_enable <= reg_wdata[`TX_EN_BIT];
        sync_mode <= reg_wdata[`TX_SYNC_BIT];
        send_break_request <= reg_wdata[`TX_BREAK_BIT];
        high_rate_select <= reg_wdata[`TX_HIGH_RATE_BIT];
        transmit_ninth_data_bit <= reg_wdata[`TX_NINTH_DATA_BIT];
      end
      if (wr_divl) rate_divisor[7:0] <= reg_wdata;
      if (wr_divh) rate_divisor[15:8] <= reg_wdata;
    end
  end

  // --------------------------------------------------------------------------
  // rate generator
  // --------------------------------------------------------------------------
  // restarted at half a bit on an unclocked start edge so samples land mid-bit
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) rate_cnt <= 16'h0000;
    else if (port_reset) rate_cnt <= 16'h0000;
    else if (arx_start) rate_cnt <= {1'b0, rate_divisor[15:1]};
    else rate_cnt <= tick ? rate_divisor : rate_cnt - 16'h0001;
  end

  // --------------------------------------------------------------------------
  // transmit holding register
  // --------------------------------------------------------------------------
  // the ninth bit is taken at the write, so a later ninth-bit change hits the next character
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_hold <= 9'h000;
      hold_valid <= 1'b0;
    end else if (port_reset) begin
      hold_valid <= 1'b0;
    end else if (wr_txdata) begin
      tx_hold <= {transmit_ninth_data_bit & tx_ninth_bit_enable, reg_wdata};
      hold_valid <= 1'b1; // waits here while the shifter is busy
    end else if (start_tx) begin
      hold_valid <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // shift engine
  // --------------------------------------------------------------------------
  // data only, no start/stop framing in clocked mode
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      transmit_shifter <= 9'h000;
      receive_shifter <= 9'h000;
      clk_active <= 1'b0;
      data_out <= 1'b0;
    end else if (port_reset) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      clk_active <= 1'b0;
      data_out <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          bit_cnt <= 4'h0;
          if (start_tx) begin
            transmit_shifter <= tx_hold; // loaded at once; the first bit goes out on the next leading edge
            state <= ST_TX;
          end else if (start_rx) begin
            state <= ST_RX;
          end else if (arx_start) begin
            state <= ST_ARX;
          end
        end
        ST_TX: begin
          if (lead_ev) begin
            data_out <= transmit_shifter[0]; // low bit first, ninth last
            transmit_shifter <= {1'b0, transmit_shifter[8:1]};
            clk_active <= 1'b1;
          end else if (trail_ev) begin
            clk_active <= 1'b0;
            bit_cnt <= bit_cnt + 4'h1;
            if (tx_last) state <= ST_IDLE; // no clock beyond the last bit
          end
        end
        ST_RX: begin
          if (abort_rx) begin
            clk_active <= 1'b0; // clock stops at once, partial dropped
            state <= ST_IDLE;
          end else if (lead_ev) begin
            clk_active <= 1'b1;
          end else if (trail_ev) begin
            receive_shifter <= rx_next; // sampled on trailing edge
            clk_active <= 1'b0;
            bit_cnt <= bit_cnt + 4'h1;
            if (rx_done) state <= ST_IDLE; // continuous restarts next cycle
          end
        end
        ST_ARX: begin
          if (arx_sample) begin
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == 4'h0 && din_s2) state <= ST_IDLE; // false start
            else if (bit_cnt != 4'h0 && bit_cnt <= nbits_rx) receive_shifter <= rx_next;
            if (arx_done) state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // receive queue and flags
  // --------------------------------------------------------------------------
  // overrun set beats its own clear; queue content is never overwritten
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      fifo_count <= 2'h0;
      overrun_flag <= 1'b0;
      overrun_cont <= 1'b0;
      wake_flag <= 1'b0;
    end else if (port_reset) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      fifo_count <= 2'h0;
      overrun_flag <= 1'b0;
      wake_flag <= 1'b0;
    end else begin
      if (push_req && fifo_count != 2'h2) begin
        fifo_mem[wr_ptr] <= push_word;
        wr_ptr <= ~wr_ptr;
      end
      if (rd_rxdata && !fifo_empty) rd_ptr <= ~rd_ptr;
      fifo_count <= fifo_count + {1'b0, push_req && fifo_count != 2'h2}
        - {1'b0, rd_rxdata && !fifo_empty};
      if (push_req && fifo_count == 2'h2) begin
        overrun_flag <= 1'b1;
        overrun_cont <= continuous_receive_enable;
      end else if (overrun_clear) begin
        overrun_flag <= 1'b0;
      end
      if (wake_watch && din_fall) wake_flag <= 1'b1;
      else if (rd_rxdata) wake_flag <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // pins and flags
  // --------------------------------------------------------------------------
  // idle level equals the polarity bit only a master drives the clock
  assign clock_pin_out = clk_active ^ clock_polarity_select;
  assign clock_pin_oe = master;
  // data driven whenever in transmit mode, idle or shifting, never while receiving
  assign data_line_pin_out = data_out;
  assign data_line_pin_oe = tx_mode;
  assign receive_flag = ~fifo_empty | wake_flag;
  assign transmit_flag = ~hold_valid;

  // --------------------------------------------------------------------------
  // register read
  // --------------------------------------------------------------------------
  // ninth bit and framing error follow the top unread entry
  wire [7:0] baud_rd = {1'b0, st_idle, 1'b0, clock_polarity_select, wide_divider_select,
    1'b0, wake_on_activity_enable, auto_rate_detect_enable};
  wire [7:0] receive_status_control_rd = {port_enable, rx_ninth_bit_enable, single_receive_enable,
    continuous_receive_enable, address_detect_enable, fifo_top[9] & ~fifo_empty,
    overrun_flag, fifo_top[8] & ~fifo_empty};
  wire [7:0] transmit_status_control_rd = {clock_source_master, tx_ninth_bit_enable, transmit_enable,
    sync_mode, send_break_request, high_rate_select, ~st_tx, transmit_ninth_data_bit};
  logic [7:0] read_mux;
  always_comb begin
    case (reg_addr)
      `BAUD_CONTROL_OFF: read_mux = baud_rd;
      `RECEIVE_STATUS_CONTROL_OFF: read_mux = receive_status_control_rd;
      `RATE_DIVISOR_LOW_OFF: read_mux = rate_divisor[7:0];
      `RATE_DIVISOR_HIGH_OFF: read_mux = rate_divisor[15:8];
      `TRANSMIT_STATUS_CONTROL_OFF: read_mux = transmit_status_control_rd;
      `RECEIVE_DATA_OFF: read_mux = fifo_empty ? 8'h00 : fifo_top[7:0];
      `FLAG_STATUS_OFF: read_mux = {6'h00, transmit_flag, receive_flag};
      default: read_mux = 8'h00;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) reg_rdata <= 8'h00;
    else reg_rdata <= reg_read ? read_mux : 8'h00;
  end

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_break_report: assert property (arx_done && fifo_empty && !overrun_flag && !din_s2
    && push_word[8:0] == 9'h000 |=> receive_flag && fifo_top[9] && fifo_top[7:0] == 8'h00)
    else $error("break not reported");
  a_wake_flag: assert property (wake_watch && din_fall |=> receive_flag)
    else $error("wake edge did not raise receive flag");
  a_wake_clear: assert property (wake_watch && din_rise && !wr_baud |=>
    !wake_on_activity_enable) else $error("wake enable not cleared");
  a_master_clock: assert property (st_tx && master |-> clock_pin_oe && data_line_pin_oe)
    else $error("master transmit drivers off");
  a_last_clock: assert property (tx_last && master |=> st_idle
    && clock_pin_out == clock_polarity_select) else $error("extra clock after last bit");
  a_idle_level: assert property (master && st_idle && $stable(clock_polarity_select)
    |-> clock_pin_out == clock_polarity_select) else $error("clock idle level wrong");
  a_data_hold: assert property (port_enable && !lead_ev ##1 port_enable
    |-> $stable(data_line_pin_out)) else $error("data changed off leading edge");
  a_rx_release: assert property (rx_mode |-> !data_line_pin_oe)
    else $error("data pin driven while receiving");
  a_single_clear: assert property (single_receive_enable_clear && !wr_receive_status_control |=> !single_receive_enable)
    else $error("single receive not cleared");
  a_abort_stop: assert property (st_rx && master && !wr_receive_status_control && !continuous_receive_enable
    && !single_receive_enable |=> st_idle [*2]) else $error("clock not stopped on abort");
  a_overrun_keep: assert property (push_req && fifo_count == 2'h2 && !rd_rxdata
    |=> overrun_flag && fifo_count == 2'h2) else $error("overrun not flagged");

  c_tx_done: cover property (tx_last ##1 start_tx);
  c_rx_cont: cover property (rx_done && continuous_receive_enable);
  c_overrun: cover property (overrun_flag ##1 !overrun_flag);
  c_break: cover property (arx_done && push_word == 10'h200);

endmodule

`default_nettype wire

// ---- testbench/far_peer.sv ----
// Purpose: far-side clocked serial peer for the serial port bench
// Assumes: the leading edge is the clock leaving its idle level
// Notes: bench reloads pat between frames; got keeps the last sixteen bits
`timescale 1ns/100ps
`default_nettype none
module far_peer (
  input wire logic clk_line,
  input wire logic pol,
  input wire logic dev_oe,
  input wire logic dev_data,
  output logic drive
);
  logic [8:0] pat = 9'h000;
  logic [15:0] got = 16'h0000;
  // ----------------------------------------------------------------------
  // shifting on both clock edges
  // ----------------------------------------------------------------------
  initial drive = 1'b0;
  // leading edge puts out the next bit, trailing edge takes one, lsb first
  always @(clk_line) begin
    if (clk_line != pol) begin
      drive = pat[0];
      pat = {pat[0], pat[8:1]};
    end else if (dev_oe) begin
      got = {dev_data, got[15:1]};
    end
  end
  // line released to the device: flip so a stale level cannot pass
  always @(posedge dev_oe) drive = ~drive;
endmodule
`default_nettype wire

// ---- testbench/tb_serial_port_unit.sv ----
// Purpose: self-checking bench for the clocked serial port
// Assumes: divisor 2 gives three core clocks per half bit
// Notes: reads note expectations in a queue drained by the monitor
`timescale 1ns/100ps
`default_nettype none
module tb_serial_port_unit;
  logic core_clk = 0, reset_n = 0, reg_write = 0, reg_read = 0, rd_d = 0, clock_pin_in = 0;
  logic pol = 0, clock_pin_out, clock_pin_oe, data_line_pin_out, data_line_pin_oe;
  logic receive_flag, transmit_flag, drive, clk_wire, data_wire;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, b0, b1, exp_q[$];
  logic [8:0] v;
  int n_errors = 0, compares = 0, edges = 0, cyc = 0;
  assign clk_wire = clock_pin_oe ? clock_pin_out : clock_pin_in;
  assign data_wire = data_line_pin_oe ? data_line_pin_out : drive;
  serial_port_unit uut (.core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .clock_pin_in(clk_wire), .clock_pin_out, .clock_pin_oe,
    .data_line_pin_in(data_wire), .data_line_pin_out, .data_line_pin_oe, .receive_flag,
    .transmit_flag);
  far_peer far (.clk_line(clk_wire), .pol, .dev_oe(data_line_pin_oe),
    .dev_data(data_line_pin_out), .drive);
  // ----------------------------------------------------------------------
  // clock, hang limit, read monitor
  // ----------------------------------------------------------------------
  always #12.5 core_clk = ~core_clk;
  always @(posedge clk_wire) edges++;
  always @(posedge core_clk) begin
    rd_d <= reg_read;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      give_verdict();
    end
  end
  // read data stand one cycle only, so look mid-cycle
  always @(negedge core_clk) if (rd_d) check(reg_rdata, exp_q.pop_front());
  task check(input logic [7:0] seen, input logic [7:0] want);
    compares++;
    if (seen !== want) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task give_verdict();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    {reg_addr, reg_wdata, reg_write} <= {a, d, 1'b1};
    @(posedge core_clk) reg_write <= 1'b0;
  endtask
  task rd(input logic [2:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge core_clk);
    {reg_addr, reg_read} <= {a, 1'b1};
    @(posedge core_clk) reg_read <= 1'b0;
  endtask
  task pause(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  initial begin
    b0 = 8'($urandom(32'h8f4f5bc1));
    pause(20);
    reset_n <= 1;
    rd(3'h4, 8'h00);
    rd(3'h7, 8'h02);
    {b0, b1} = 16'($urandom);
    wr(3'h2, 8'h02);
    wr(3'h1, 8'h80);
    wr(3'h5, 8'hB0);
    edges = 0;
    wr(3'h4, b0);
    wr(3'h4, b1);
    check({7'h0, clock_pin_oe & data_line_pin_oe}, 8'h01);
    pause(250);
    check(far.got[7:0], b0);
    check(far.got[15:8], b1);
    check(edges[7:0], 8'h10);
    $display("test transmit done");
    v = 9'($urandom);
    far.pat = v;
    edges = 0;
    wr(3'h5, 8'h90);
    wr(3'h1, 8'hA0);
    pause(4);
    check({7'h0, data_line_pin_oe}, 8'h00);
    pause(150);
    check(edges[7:0], 8'h08);
    rd(3'h1, 8'h80);
    rd(3'h7, 8'h03);
    rd(3'h6, v[7:0]);
    rd(3'h7, 8'h02);
    // single and continuous together, nine bits, run into overrun
    v = 9'($urandom);
    far.pat = v;
    wr(3'h1, 8'hF0);
    pause(400);
    rd(3'h1, {7'h69, v[8]});
    rd(3'h6, v[7:0]);
    rd(3'h1, {7'h69, v[8]});
    wr(3'h1, 8'hC0);
    rd(3'h1, {7'h60, v[8]});
    rd(3'h6, v[7:0]);
    $display("test receive done");
    pol = 1;
    wr(3'h0, 8'h10);
    pause(3);
    check({7'h0, clock_pin_out}, 8'h01);
    wr(3'h0, 8'h00);
    pol = 0;
    wr(3'h5, 8'h10);
    // the mode write lands on the edge the task returns at, so let it settle
    pause(1);
    check({7'h0, clock_pin_oe}, 8'h00);
    v = 9'($urandom);
    far.pat = v;
    wr(3'h1, 8'h90);
    // one 200 ns link clock period per data bit, no extra periods
    repeat (8) begin
      pause(4);
      clock_pin_in <= 1'b1;
      pause(4);
      clock_pin_in <= 1'b0;
    end
    pause(10);
    rd(3'h6, v[7:0]);
    pause(2);
    $display("test slave done");
    // unclocked break: line held low past the stop bit, then wake on activity
    wr(3'h5, 8'h00);
    far.drive <= 1'b1;
    pause(5);
    far.drive <= 1'b0;
    pause(40);
    far.drive <= 1'b1;
    pause(5);
    check({6'h00, transmit_flag, receive_flag}, 8'h03);
    rd(3'h1, 8'h94);
    rd(3'h6, 8'h00);
    wr(3'h0, 8'h02);
    far.drive <= 1'b0;
    pause(5);
    check({7'h00, receive_flag}, 8'h01);
    far.drive <= 1'b1;
    pause(5);
    rd(3'h0, 8'h40);
    rd(3'h6, 8'h00);
    rd(3'h7, 8'h02);
    $display("test break done");
    give_verdict();
  end
endmodule
`default_nettype wire
